// >>> verilog/uart_rx_pkg.sv
// package: constants, register map and carrier types for the serial receiver
package uart_rx_pkg;
   // apb register byte offsets
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] status_offset = 8'h04;
   localparam logic [7:0] data_offset = 8'h08;
   localparam logic [7:0] divisor_offset = 8'h0c;
   // control field positions
   localparam int double_speed_pos = 0;
   localparam int filter_enable_pos = 1;
   localparam int size_code_lo_pos = 2;
   localparam int rx_enable_pos = 5;
   // values after reset
   localparam logic [15:0] divisor_reset = 16'h0000;
   localparam logic [2:0] size_code_reset = 3'h3;
   // sample counts and the nine-bit size code
   localparam logic [4:0] samples_normal = 5'h10;
   localparam logic [4:0] samples_double = 5'h08;
   localparam logic [4:0] vote_first_normal = 5'h08;
   localparam logic [4:0] vote_first_double = 5'h04;
   localparam logic [2:0] nine_bit_code = 3'h7;
   // received frame carrier
   typedef struct packed {
      logic frame_error;
      logic ninth_bit;
      logic [7:0] data;
   } rx_frame_t;
endpackage : uart_rx_pkg

// >>> verilog/rx_line_sync.sv
// three-stage synchroniser for the receive pin with agreement check
`timescale 1ns/1ps
`default_nettype none
module rx_line_sync
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // raw pin and filtered level
   input wire logic rxd_pin,
   output logic rxd_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // first stage read only by the second; level changes when 2 and 3 agree
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         rxd_level <= 1'b1;
      end
      else
      begin
         s1_q <= rxd_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            rxd_level <= s3_q;
      end
   end
endmodule : rx_line_sync
`default_nettype wire

// >>> verilog/uart_rx_recovery_multidrop.sv
// serial receiver: start detect, majority vote, frame check, address filter
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recovery_multidrop
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rxd_pin
);
   typedef enum logic [1:0] {st_idle, st_start, st_bits} rx_state_t;

   logic rxd_level;
   logic rxd_prev_q;
   logic [15:0] divisor_q;
   logic [15:0] div_cnt_q;
   logic tick;
   logic double_speed_q;
   logic filter_enable_q;
   logic rx_enable_q;
   logic [2:0] size_code_q;
   rx_state_t state_q;
   logic [4:0] sample_q;
   logic [3:0] bit_idx_q;
   logic [2:0] vote_q;
   logic [8:0] shift_q;
   uart_rx_pkg::rx_frame_t frame_q;
   logic rx_complete_q;
   logic overrun_q;
   logic frame_done;
   logic frame_keep;
   logic [3:0] data_bits;
   logic [4:0] spb;
   logic [4:0] vfirst;
   logic voted;
   logic setup_ok;
   logic data_read;
   logic bit_end;

   function automatic logic majority(input logic [2:0] v);
      majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : majority

   function automatic logic [3:0] size_bits(input logic [2:0] code);
      size_bits = (code == uart_rx_pkg::nine_bit_code) ? 4'h9
                : 4'(code[1:0]) + 4'h5;
   endfunction : size_bits

   rx_line_sync u_sync
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .rxd_pin(rxd_pin),
      .rxd_level(rxd_level)
   );

   assign spb = double_speed_q ? uart_rx_pkg::samples_double
                               : uart_rx_pkg::samples_normal;
   assign vfirst = double_speed_q ? uart_rx_pkg::vote_first_double
                                  : uart_rx_pkg::vote_first_normal;
   assign data_bits = size_bits(size_code_q);
   assign voted = majority({vote_q[1:0], rxd_level});
   assign setup_ok = psel & ~penable;
   assign data_read = psel & penable & ~pwrite &
                      (paddr == uart_rx_pkg::data_offset);
   // last voting sample of a bit ends it early: allows a quick restart
   assign bit_end = tick & (sample_q == vfirst + 5'h2);

   // sample tick divider: one pulse every divisor+1 system clocks
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || !rx_enable_q)
         div_cnt_q <= 16'h0000;
      else if (div_cnt_q >= divisor_q)
         div_cnt_q <= 16'h0000;
      else
         div_cnt_q <= div_cnt_q + 16'h0001;
   end
   assign tick = rx_enable_q & (div_cnt_q >= divisor_q);

   // receive state machine
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || !rx_enable_q)
      begin
         state_q <= st_idle;
         sample_q <= 5'h00;
         bit_idx_q <= 4'h0;
         vote_q <= 3'h0;
         shift_q <= 9'h000;
         rxd_prev_q <= 1'b1;
      end
      else if (tick)
      begin
         rxd_prev_q <= rxd_level;
         unique case (state_q)
            st_idle:
            begin
               sample_q <= 5'h00;
               if (rxd_prev_q && !rxd_level)
               begin
                  state_q <= st_start;
                  sample_q <= 5'h01;
               end
            end
            st_start:
            begin
               sample_q <= sample_q + 5'h01;
               if (sample_q >= vfirst && sample_q <= vfirst + 5'h2)
                  vote_q <= {vote_q[1:0], rxd_level};
               if (sample_q == vfirst + 5'h2)
               begin
                  if (majority({vote_q[1:0], rxd_level}))
                  begin
                     state_q <= st_idle;
                     sample_q <= 5'h00;
                  end
                  else
                  begin
                     bit_idx_q <= 4'h0;
                     // cleared so short frames leave unused bits at zero
                     shift_q <= 9'h000;
                  end
               end
               if (sample_q == spb)
               begin
                  state_q <= st_bits;
                  sample_q <= 5'h01;
               end
            end
            st_bits:
            begin
               sample_q <= (sample_q == spb) ? 5'h01 : sample_q + 5'h01;
               if (sample_q >= vfirst && sample_q <= vfirst + 5'h2)
                  vote_q <= {vote_q[1:0], rxd_level};
               if (sample_q == spb)
                  bit_idx_q <= bit_idx_q + 4'h1;
               if (sample_q == vfirst + 5'h2 && bit_idx_q < data_bits)
                  shift_q[bit_idx_q] <= majority({vote_q[1:0], rxd_level});
               if (sample_q == vfirst + 5'h2 && bit_idx_q == data_bits)
               begin
                  state_q <= st_idle;
                  sample_q <= 5'h00;
                  rxd_prev_q <= 1'b1;
               end
            end
            default:
               state_q <= st_idle;
         endcase
      end
   end

   // stop bit voted this tick: frame ends, extra stop bits never examined
   assign frame_done = bit_end & (state_q == st_bits) &
                       (bit_idx_q == data_bits);
   // frame type: ninth bit for nine-bit frames, else the first stop bit
   assign frame_keep = !filter_enable_q ||
      ((size_code_q == uart_rx_pkg::nine_bit_code) ? shift_q[8]
       : majority({vote_q[1:0], rxd_level}));

   // receive holding register and flags; set beats the read clear
   always_ff @(posedge clk_sys)
   begin
      if (!resetn || !rx_enable_q)
      begin
         frame_q <= '0;
         rx_complete_q <= 1'b0;
         overrun_q <= 1'b0;
      end
      else if (frame_done && frame_keep)
      begin
         frame_q.data <= shift_q[7:0];
         frame_q.ninth_bit <= shift_q[8];
         frame_q.frame_error <= ~majority({vote_q[1:0], rxd_level});
         rx_complete_q <= 1'b1;
         overrun_q <= rx_complete_q & ~data_read;
      end
      else if (data_read)
      begin
         // the buffer is empty once read: its flags leave with the frame
         rx_complete_q <= 1'b0;
         frame_q.frame_error <= 1'b0;
         overrun_q <= 1'b0;
      end
   end

   // control register writes; filter enable alone steers only the receiver
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         double_speed_q <= 1'b0;
         filter_enable_q <= 1'b0;
         rx_enable_q <= 1'b0;
         size_code_q <= uart_rx_pkg::size_code_reset;
         divisor_q <= uart_rx_pkg::divisor_reset;
      end
      else if (psel && penable && pwrite)
      begin
         if (paddr == uart_rx_pkg::ctrl_offset)
         begin
            double_speed_q <= pwdata[uart_rx_pkg::double_speed_pos];
            filter_enable_q <= pwdata[uart_rx_pkg::filter_enable_pos];
            rx_enable_q <= pwdata[uart_rx_pkg::rx_enable_pos];
            size_code_q <= pwdata[uart_rx_pkg::size_code_lo_pos +: 3];
         end
         if (paddr == uart_rx_pkg::divisor_offset)
            divisor_q <= pwdata[15:0];
      end
   end

   // apb: no wait states, read data registered in the setup cycle
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setup_ok;
         pslverr <= setup_ok & (paddr[1:0] != 2'h0 ||
                   paddr > uart_rx_pkg::divisor_offset);
         if (setup_ok && !pwrite)
         begin
            unique case (paddr)
               uart_rx_pkg::ctrl_offset:
                  prdata <= {26'h0, rx_enable_q, size_code_q,
                             filter_enable_q, double_speed_q};
               uart_rx_pkg::status_offset:
                  prdata <= {29'h0, overrun_q, frame_q.frame_error,
                             rx_complete_q};
               uart_rx_pkg::data_offset:
                  prdata <= {23'h0, frame_q.ninth_bit, frame_q.data};
               uart_rx_pkg::divisor_offset:
                  prdata <= {16'h0, divisor_q};
               default:
                  prdata <= 32'h00000000;
            endcase
         end
      end
   end

   AST_FRAME_ERR: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_done && frame_keep |=> frame_q.frame_error == $past(~voted))
      else $error("frame error does not follow stop bit");
   AST_RXC_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_done && frame_keep |=> rx_complete_q)
      else $error("receive complete not set");
   AST_FILTER: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_done && !frame_keep && !data_read |=> $stable(rx_complete_q) &&
      $stable(frame_q))
      else $error("filtered frame reached buffer");
   AST_NOISE: assert property (@(posedge clk_sys) disable iff (!resetn)
      tick && state_q == st_start && sample_q == vfirst + 5'h2 &&
      majority({vote_q[1:0], rxd_level}) |=> state_q == st_idle)
      else $error("noise start not rejected");
   AST_IDLE_CNT: assert property (@(posedge clk_sys) disable iff (!resetn)
      state_q == st_idle && $past(state_q) == st_idle |-> sample_q == 5'h00)
      else $error("counter runs while idle");
   AST_CNT_RANGE: assert property (@(posedge clk_sys) disable iff (!resetn)
      sample_q <= spb)
      else $error("sample counter past bit length");
   AST_REARM: assert property (@(posedge clk_sys) disable iff (!resetn)
      frame_done |=> state_q == st_idle)
      else $error("not ready after stop vote");
   AST_START_GO: assert property (@(posedge clk_sys) disable iff (!resetn)
      tick && state_q == st_idle && rxd_prev_q && !rxd_level
      |=> state_q == st_start && sample_q == 5'h01)
      else $error("start detection missed");
endmodule : uart_rx_recovery_multidrop
`default_nettype wire

// >>> verification/uart_tx_partner.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uart_tx_partner
(
   // clock
   input wire logic clk_sys,
   // frame request
   input wire logic go,
   input wire logic [8:0] frame,
   input wire logic [3:0] nbits,
   input wire logic [1:0] nstop,
   input wire logic stop_val,
   input wire logic glitch,
   input wire logic [7:0] bit_clks,
   // line and state
   output logic txd,
   output logic busy
);
   initial txd = 1'b1;
   initial busy = 1'b0;
   task automatic hold(input logic v, input int n);
      txd <= v;
      repeat (n) @(posedge clk_sys);
   endtask : hold
   always @(posedge clk_sys)
   begin
      if (go)
      begin
         busy <= 1'b1;
         // spike far shorter than the centre samples
         if (glitch)
            hold(1'b0, bit_clks / 8);
         else
         begin
            hold(1'b0, bit_clks);
            for (int i = 0; i < nbits; i++)
               hold(frame[i], bit_clks);
            for (int i = 0; i < nstop; i++)
               hold(i == 0 ? stop_val : 1'b1, bit_clks);
         end
         txd <= 1'b1;
         busy <= 1'b0;
      end
   end
endmodule : uart_tx_partner
`default_nettype wire

// >>> verification/uart_rx_recovery_multidrop_tb_top.sv
// self-checking bench: apb master, frame stimulus, flag checks
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recovery_multidrop_tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxd;
   logic go = 1'b0;
   logic [8:0] frame = 9'h0;
   logic [3:0] nbits = 4'h8;
   logic [1:0] nstop = 2'h1;
   logic stop_val = 1'b1;
   logic glitch = 1'b0;
   logic [7:0] bit_clks = 8'h40;
   logic busy;
   logic [31:0] seed = 32'h00d5a6c7;
   logic [7:0] a_ctl = uart_rx_pkg::ctrl_offset;
   logic [7:0] a_st = uart_rx_pkg::status_offset;
   logic [7:0] a_dat = uart_rx_pkg::data_offset;
   logic [7:0] a_div = uart_rx_pkg::divisor_offset;
   int miscompares = 0;
   int total_checks = 0;
   always #2 clk_sys = ~clk_sys;
   uart_rx_recovery_multidrop u_uart_rx_recovery_multidrop
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .rxd_pin(rxd)
   );
   uart_tx_partner u_uart_tx_partner
   (
      .clk_sys(clk_sys),
      .go(go),
      .frame(frame),
      .nbits(nbits),
      .nstop(nstop),
      .stop_val(stop_val),
      .glitch(glitch),
      .bit_clks(bit_clks),
      .txd(rxd),
      .busy(busy)
   );
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] exp_data(input logic [8:0] f,
      input logic [3:0] nb);
      return {23'h0, f & (9'h1ff >> (4'h9 - nb))};
   endfunction : exp_data
   function automatic logic [31:0] exp_ctrl(input logic en,
      input logic [2:0] c, input logic fl, input logic d);
      return {26'h0, en, c, fl, d};
   endfunction : exp_ctrl
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic x);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         miscompares++;
         $display("[ERR] %0t no ready on register bus", $time);
         final_report;
      end
      r = prdata;
      x = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic ee);
      logic [31:0] r;
      logic x;
      apb(1'b0, a, 32'h0, r, x);
      check(r, e);
      check(32'(x), 32'(ee));
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic ee);
      logic [31:0] r;
      logic x;
      apb(1'b1, a, d, r, x);
      check(32'(x), 32'(ee));
   endtask : wr
   // sends one frame and waits until the line is idle again
   task automatic xmit(input logic [8:0] f, input logic [3:0] nb,
      input logic sv, input logic [1:0] ns, input logic gl, input logic d);
      int n;
      n = 0;
      @(posedge clk_sys);
      frame <= f;
      nbits <= nb;
      stop_val <= sv;
      nstop <= ns;
      glitch <= gl;
      bit_clks <= d ? 8'h20 : 8'h40;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (busy !== 1'b0 && n < 2000);
      if (n >= 2000)
      begin
         miscompares++;
         $display("[ERR] %0t line model stuck busy", $time);
         final_report;
      end
      repeat (16) @(posedge clk_sys);
   endtask : xmit
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report;
   end
   initial
   begin
      logic [8:0] f;
      logic [2:0] c;
      logic [3:0] nb;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(a_ctl, exp_ctrl(1'b0, 3'h3, 1'b0, 1'b0), 1'b0);
      rd(a_st, 32'h0, 1'b0);
      rd(a_div, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b1);
      wr(8'h02, 32'h3f, 1'b1);
      rd(a_ctl, exp_ctrl(1'b0, 3'h3, 1'b0, 1'b0), 1'b0);
      // divisor 3: one sample tick every four clocks
      wr(a_div, 32'h3, 1'b0);
      rd(a_div, 32'h3, 1'b0);
      for (int d = 0; d < 2; d++)
         for (int k = 0; k < 5; k++)
         begin
            c = (k == 4) ? 3'h7 : 3'(k);
            nb = (k == 4) ? 4'h9 : 4'(k + 5);
            wr(a_ctl, exp_ctrl(1'b1, c, 1'b0, d[0]), 1'b0);
            seed = lfsr(seed);
            f = seed[8:0];
            xmit(f, nb, 1'b1, 2'h1, 1'b0, d[0]);
            rd(a_st, 32'h1, 1'b0);
            rd(a_dat, exp_data(f, nb), 1'b0);
            rd(a_st, 32'h0, 1'b0);
         end
      wr(a_ctl, exp_ctrl(1'b1, 3'h3, 1'b0, 1'b0), 1'b0);
      xmit(seed[8:0], 4'h8, 1'b0, 2'h1, 1'b0, 1'b0);
      rd(a_st, 32'h3, 1'b0);
      rd(a_dat, exp_data(seed[8:0], 4'h8), 1'b0);
      xmit(9'h0, 4'h8, 1'b1, 2'h1, 1'b1, 1'b0);
      rd(a_st, 32'h0, 1'b0);
      seed = lfsr(seed);
      xmit(9'h0a5, 4'h8, 1'b1, 2'h1, 1'b0, 1'b0);
      xmit(seed[8:0], 4'h8, 1'b1, 2'h1, 1'b0, 1'b0);
      rd(a_st, 32'h5, 1'b0);
      rd(a_dat, exp_data(seed[8:0], 4'h8), 1'b0);
      // type bit: first stop for 8-bit, ninth bit for 9-bit frames
      for (int j = 0; j < 4; j++)
      begin
         c = j[1] ? 3'h7 : 3'h3;
         nb = j[1] ? 4'h9 : 4'h8;
         seed = lfsr(seed);
         f = {j[0], seed[7:0]};
         wr(a_ctl, exp_ctrl(1'b1, c, 1'b1, 1'b0), 1'b0);
         xmit(f, nb, j[1] | j[0], 2'h2, 1'b0, 1'b0);
         rd(a_st, 32'(j[0]), 1'b0);
         if (j[0])
            rd(a_dat, exp_data(f, nb), 1'b0);
      end
      // selected node: filter off takes data frames, then back on drops them
      seed = lfsr(seed);
      f = {1'b0, seed[7:0]};
      wr(a_ctl, exp_ctrl(1'b1, 3'h7, 1'b0, 1'b0), 1'b0);
      xmit(f, 4'h9, 1'b1, 2'h1, 1'b0, 1'b0);
      rd(a_st, 32'h1, 1'b0);
      rd(a_dat, exp_data(f, 4'h9), 1'b0);
      wr(a_ctl, exp_ctrl(1'b1, 3'h7, 1'b1, 1'b0), 1'b0);
      xmit(f, 4'h9, 1'b1, 2'h1, 1'b0, 1'b0);
      rd(a_st, 32'h0, 1'b0);
      final_report;
   end
endmodule : uart_rx_recovery_multidrop_tb_top
`default_nettype wire
